// [host_chipset_model.sv]
// host chipset model sampling the wake and SYSTEM_MGMT_INTERRUPT_N requests
`timescale 1ns/1ns
module host_chipset_model (
  // clock
  input  wire logic clk,
  // requests from the device, active low
  input  wire logic wakeReq_n,
  input  wire logic smiReq_n,
  // sampled request levels, active high
  output logic      wakeSeen,
  output logic      smiSeen
);
  // ==========================================================================
  // requests are levels, so one sampling flop is all the host needs
  always_ff @(posedge clk) begin
    wakeSeen <= !wakeReq_n;
    smiSeen  <= !smiReq_n;
  end
endmodule // host_chipset_model

// [wake_event_enable_routing.sv]
// wake event status, enable, configuration and SYSTEM_MGMT_INTERRUPT_N routing behind AXI4-Lite
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
// ============================================================================
// What this block does
// - all six control registers reset to zero
// - wake request low when enabled event detected
// - enable 0: irq, sw, gpio, ir, mouse, keyboard, rings
// - enable 1: one bit per general input event
// - config bits 1-0 select register bank
// - config bit 3 enables S3 button pulse
// - config bit 2 swaps keyboard and mouse inputs
// - SYSTEM_MGMT_INTERRUPT_N routing works regardless of wake enables
// - SYSTEM_MGMT_INTERRUPT_N routing bit map, bits 7,5 reserved
// - SYSTEM_MGMT_INTERRUPT_N routing register visible only in bank 2
// - status bits sticky, write one clears, except the software event bit
// - writing one inverts software event status
module wake_event_enable_routing (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // detected events, one-cycle pulses (bit 6 of group 0 is unused)
  input  wire logic [7:0]  moduleEvents,
  input  wire logic [7:0]  generalInputEvents,
  // keyboard and mouse line inputs and their routed copies
  input  wire logic        keyboardClockIn,
  input  wire logic        keyboardDataIn,
  input  wire logic        mouseClockIn,
  input  wire logic        mouseDataIn,
  output logic             keysCtrlKeyboardClock,
  output logic             keysCtrlKeyboardData,
  output logic             keysCtrlMouseClock,
  output logic             keysCtrlMouseData,
  // requests to the host chipset and local controls
  output logic             powerWakeRequest_n,
  output logic             systemMgmtInterrupt_n,
  output logic             powerButtonPulseS3En,
  output logic             irq
);

  // ==========================================================================
  // decode helpers
  function automatic logic regHit(input logic [5:0] idx, input logic [1:0] bank);
    logic hit;
    hit = 1'b0;
    case (idx)
      wake_event_pkg::IDX_STATUS_0,
      wake_event_pkg::IDX_STATUS_1,
      wake_event_pkg::IDX_WAKE_EN_0,
      wake_event_pkg::IDX_WAKE_EN_1,
      wake_event_pkg::IDX_WAKE_CFG,
      wake_event_pkg::IDX_IRQ_MASK_0,
      wake_event_pkg::IDX_IRQ_MASK_1: hit = 1'b1;
      // the routing slot answers in every bank but only holds data in bank 2
      wake_event_pkg::IDX_SMI_EN_0:   hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [5:0] wordIndex(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  // ==========================================================================
  // registers
  logic [7:0]  status0_ff;
  logic [7:0]  status1_ff;
  logic [7:0]  wakeEnable0_ff;
  logic [7:0]  wakeEnable1_ff;
  logic [7:0]  wakeConfiguration_ff;
  logic [7:0]  smiRoutingEnable0_ff;
  logic [7:0]  irqMask0_ff;
  logic [7:0]  irqMask1_ff;
  logic [7:0]  awAddrHeld_ff;
  logic        awHeld_ff;
  logic [7:0]  wDataHeld_ff;
  logic        wLaneHeld_ff;
  logic        wHeld_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        wakeReq_n_ff;
  logic        smi_n_ff;
  logic [3:0]  keysCtrlLines_ff;

  // ==========================================================================
  // write decode
  // a held write lands one clock after both of its channels are taken
  wire logic [5:0] wrIdx      = wordIndex(awAddrHeld_ff);
  wire logic [1:0] bankSel    = wakeConfiguration_ff[1:0];
  wire logic       wrFire     = awHeld_ff && wHeld_ff && !bvalid_ff;
  wire logic       wrHit      = regHit(wrIdx, bankSel);
  wire logic       wrDo       = wrFire && wrHit && wLaneHeld_ff;
  wire logic       wrSts0     = wrDo && (wrIdx == wake_event_pkg::IDX_STATUS_0);
  wire logic       wrSts1     = wrDo && (wrIdx == wake_event_pkg::IDX_STATUS_1);
  wire logic       wrEn0      = wrDo && (wrIdx == wake_event_pkg::IDX_WAKE_EN_0);
  wire logic       wrEn1      = wrDo && (wrIdx == wake_event_pkg::IDX_WAKE_EN_1);
  wire logic       wrCfg      = wrDo && (wrIdx == wake_event_pkg::IDX_WAKE_CFG);
  wire logic       wrSmi      = wrDo && (wrIdx == wake_event_pkg::IDX_SMI_EN_0)
                                && (bankSel == wake_event_pkg::BANK_ROUTING);
  wire logic       wrMask0    = wrDo && (wrIdx == wake_event_pkg::IDX_IRQ_MASK_0);
  wire logic       wrMask1    = wrDo && (wrIdx == wake_event_pkg::IDX_IRQ_MASK_1);

  // ==========================================================================
  // status next values: a new event wins over a clear in the same cycle
  wire logic [7:0] clr0       = wrSts0 ? wDataHeld_ff : 8'h00;
  wire logic [7:0] clr1       = wrSts1 ? wDataHeld_ff : 8'h00;
  wire logic [7:0] hwEvents0  = moduleEvents & ~(8'h01 << wake_event_pkg::SW_EVENT_BIT);
  wire logic [7:0] swToggle   = clr0 & (8'h01 << wake_event_pkg::SW_EVENT_BIT);
  wire logic [7:0] nxt_status0 =
    ((status0_ff & ~clr0) | hwEvents0) & ~(8'h01 << wake_event_pkg::SW_EVENT_BIT)
    | ((status0_ff ^ swToggle) & (8'h01 << wake_event_pkg::SW_EVENT_BIT));
  wire logic [7:0] nxt_status1 = (status1_ff & ~clr1) | generalInputEvents;

  // ==========================================================================
  // request outputs
  wire logic [7:0] wakeHits0  = status0_ff & wakeEnable0_ff;
  wire logic [7:0] wakeHits1  = status1_ff & wakeEnable1_ff;
  wire logic       nxt_wakeReq_n = ~(|wakeHits0 | |wakeHits1);
  wire logic       nxt_smi_n  = ~(|(status0_ff & smiRoutingEnable0_ff));
  wire logic       swapLines  = wakeConfiguration_ff[wake_event_pkg::CFG_SWAP_BIT];
  wire logic [3:0] nxt_keysCtrlLines = swapLines
    ? {mouseClockIn, mouseDataIn, keyboardClockIn, keyboardDataIn}
    : {keyboardClockIn, keyboardDataIn, mouseClockIn, mouseDataIn};

  // ==========================================================================
  // read decode
  wire logic [5:0] rdIdx      = wordIndex(araddr);
  wire logic       arFire     = arvalid && !rvalid_ff;
  wire logic       rdHit      = regHit(rdIdx, bankSel);
  logic [7:0]      rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (rdIdx)
      wake_event_pkg::IDX_STATUS_0:   rdByte = status0_ff;
      wake_event_pkg::IDX_STATUS_1:   rdByte = status1_ff;
      wake_event_pkg::IDX_WAKE_EN_0:  rdByte = wakeEnable0_ff;
      wake_event_pkg::IDX_WAKE_EN_1:  rdByte = wakeEnable1_ff;
      wake_event_pkg::IDX_WAKE_CFG:   rdByte = wakeConfiguration_ff;
      wake_event_pkg::IDX_SMI_EN_0: begin
        // other banks own this slot; their registers live elsewhere
        if (bankSel == wake_event_pkg::BANK_ROUTING) begin
          rdByte = smiRoutingEnable0_ff;
        end
      end
      wake_event_pkg::IDX_IRQ_MASK_0: rdByte = irqMask0_ff;
      wake_event_pkg::IDX_IRQ_MASK_1: rdByte = irqMask1_ff;
      default:                        rdByte = 8'h00;
    endcase
  end

  // ==========================================================================
  // bus channel holding registers
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_ff     <= 1'b0;
      awAddrHeld_ff <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_ff     <= 1'b1;
      awAddrHeld_ff <= awaddr;
    end else if (wrFire) begin
      awHeld_ff     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wHeld_ff     <= 1'b0;
      wDataHeld_ff <= 8'h00;
      wLaneHeld_ff <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_ff     <= 1'b1;
      wDataHeld_ff <= wdata[7:0];
      wLaneHeld_ff <= wstrb[0];
    end else if (wrFire) begin
      wHeld_ff     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= wake_event_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wrHit ? wake_event_pkg::RESP_OKAY : wake_event_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= wake_event_pkg::RESP_OKAY;
    end else if (arFire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rdByte};
      rresp_ff  <= rdHit ? wake_event_pkg::RESP_OKAY : wake_event_pkg::RESP_DECERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // control and status registers
  always_ff @(posedge clk) begin
    if (srst) begin
      wakeEnable0_ff       <= wake_event_pkg::RESET_VALUE;
      wakeEnable1_ff       <= wake_event_pkg::RESET_VALUE;
      wakeConfiguration_ff <= wake_event_pkg::RESET_VALUE;
      smiRoutingEnable0_ff <= wake_event_pkg::RESET_VALUE;
      irqMask0_ff          <= wake_event_pkg::RESET_VALUE;
      irqMask1_ff          <= wake_event_pkg::RESET_VALUE;
      status0_ff           <= wake_event_pkg::RESET_VALUE;
      status1_ff           <= wake_event_pkg::RESET_VALUE;
    end else begin
      status0_ff <= nxt_status0;
      status1_ff <= nxt_status1;
      if (wrEn0) begin
        wakeEnable0_ff <= wDataHeld_ff;
      end
      if (wrEn1) begin
        wakeEnable1_ff <= wDataHeld_ff;
      end
      if (wrCfg) begin
        wakeConfiguration_ff <= wDataHeld_ff & wake_event_pkg::CFG_WRITE_MASK;
      end
      if (wrSmi) begin
        smiRoutingEnable0_ff <= wDataHeld_ff & wake_event_pkg::SMI_WRITE_MASK;
      end
      if (wrMask0) begin
        irqMask0_ff <= wDataHeld_ff;
      end
      if (wrMask1) begin
        irqMask1_ff <= wDataHeld_ff;
      end
    end
  end

  // ==========================================================================
  // registered outputs
  // requests leave through flops so decode glitches never reach the host;
  // the cost is one clock of latency on the requests and the swapped lines
  always_ff @(posedge clk) begin
    if (srst) begin
      wakeReq_n_ff <= 1'b1;
      smi_n_ff     <= 1'b1;
      keysCtrlLines_ff <= 4'h0;
    end else begin
      wakeReq_n_ff <= nxt_wakeReq_n;
      smi_n_ff     <= nxt_smi_n;
      keysCtrlLines_ff <= nxt_keysCtrlLines;
    end
  end

  // ==========================================================================
  // port assignments
  // one write in flight: both channels stall while a response is pending
  assign awready               = !awHeld_ff && !bvalid_ff;
  assign wready                = !wHeld_ff && !bvalid_ff;
  assign bvalid                = bvalid_ff;
  assign bresp                 = bresp_ff;
  assign arready               = !rvalid_ff;
  assign rvalid                = rvalid_ff;
  assign rdata                 = rdata_ff;
  assign rresp                 = rresp_ff;
  assign powerWakeRequest_n    = wakeReq_n_ff;
  assign systemMgmtInterrupt_n = smi_n_ff;
  assign powerButtonPulseS3En  = wakeConfiguration_ff[wake_event_pkg::CFG_PB_S3_BIT];
  assign irq                   = |(status0_ff & irqMask0_ff) | |(status1_ff & irqMask1_ff);
  assign keysCtrlKeyboardClock = keysCtrlLines_ff[3];
  assign keysCtrlKeyboardData  = keysCtrlLines_ff[2];
  assign keysCtrlMouseClock    = keysCtrlLines_ff[1];
  assign keysCtrlMouseData     = keysCtrlLines_ff[0];

endmodule // wake_event_enable_routing

// [wake_event_enable_routing_properties.sv]
// port-level checks for the wake event enable and routing block
`timescale 1ns/1ns
module wake_event_enable_routing_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // events and line inputs
  input wire logic [7:0]  moduleEvents,
  input wire logic [7:0]  generalInputEvents,
  input wire logic        keyboardClockIn,
  input wire logic        mouseClockIn,
  // outputs
  input wire logic        keysCtrlKeyboardClock,
  input wire logic        keysCtrlMouseClock,
  input wire logic        powerWakeRequest_n,
  input wire logic        systemMgmtInterrupt_n,
  input wire logic        powerButtonPulseS3En,
  input wire logic        irq
);
  // ==========================================================================
  // causes: any event pulse, or a write address or data channel handshake
  wire eventSeen = |{moduleEvents, generalInputEvents};
  wire writeSeen = (awvalid && awready) || (wvalid && wready);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  AST_AR_TO_R: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer not held");
  AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // the taken write is held one clock, then lands and answers on the same edge
  AST_W_TO_B: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer not held");
  AST_SWAP: assert property (!$past(srst) |->
    (keysCtrlKeyboardClock == $past(keyboardClockIn) &&
     keysCtrlMouseClock == $past(mouseClockIn)) ||
    (keysCtrlKeyboardClock == $past(mouseClockIn) &&
     keysCtrlMouseClock == $past(keyboardClockIn)))
    else $error("keyboard and mouse routing broken");
  // a write lands one clock later than an event, so its cause lies one clock further back
  AST_WAKE_CAUSE: assert property ($fell(powerWakeRequest_n) |->
    $past(eventSeen, 2) || $past(writeSeen, 3))
    else $error("wake request without cause");
  AST_SMI_CAUSE: assert property ($fell(systemMgmtInterrupt_n) |->
    $past(eventSeen, 2) || $past(writeSeen, 3))
    else $error("SYSTEM_MGMT_INTERRUPT_N without cause");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(eventSeen) || $past(writeSeen, 2))
    else $error("irq without cause");
  AST_PB_CAUSE: assert property ($changed(powerButtonPulseS3En) |-> $past(writeSeen, 2))
    else $error("button pulse enable changed without write");
endmodule // wake_event_enable_routing_checker

bind wake_event_enable_routing wake_event_enable_routing_checker wake_event_enable_routing_checker_i (.*);

// [wake_event_enable_routing_test.sv]
// self-checking bench for the wake event enable and routing block
`timescale 1ns/1ns
module wake_event_enable_routing_test;
  logic        clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, moduleEvents = 8'h00, generalInputEvents = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp;
  logic        keyboardClockIn = 1'b0, keyboardDataIn = 1'b0, mouseClockIn = 1'b0;
  logic        mouseDataIn = 1'b0, keysCtrlKeyboardClock, keysCtrlKeyboardData;
  logic        keysCtrlMouseClock, keysCtrlMouseData;
  logic        powerWakeRequest_n, systemMgmtInterrupt_n, powerButtonPulseS3En, irq;
  logic        wakeSeen, smiSeen;
  logic [7:0]  m, v;
  logic [5:0]  ix [8] = '{wake_event_pkg::IDX_STATUS_0, wake_event_pkg::IDX_STATUS_1,
    wake_event_pkg::IDX_WAKE_EN_0, wake_event_pkg::IDX_WAKE_EN_1, wake_event_pkg::IDX_WAKE_CFG,
    wake_event_pkg::IDX_SMI_EN_0, wake_event_pkg::IDX_IRQ_MASK_0, wake_event_pkg::IDX_IRQ_MASK_1};
  integer      seed = 32'h03AA;
  int          error_cnt = 0, tests_run = 0, b;
  wake_event_enable_routing wake_event_enable_routing_i (.*);
  host_chipset_model host_chipset_model_i (.clk(clk), .wakeReq_n(powerWakeRequest_n),
    .smiReq_n(systemMgmtInterrupt_n), .wakeSeen(wakeSeen), .smiSeen(smiSeen));
  always #4 clk = ~clk;
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [3:0] expSwap(input logic swap, input logic [3:0] lines);
    return swap ? {lines[1:0], lines[3:2]} : lines;
  endfunction
  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ready is sampled at the falling edge, so the take edge is the next rising one
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [3:0] s = 4'hF);
    logic a, w;
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= {i, 2'h0};
    wdata <= {24'h000000, d};
    wstrb <= s;
    {a, w} = 2'h0;
    while (!(a && w)) begin
      @(negedge clk);
      a = a || awready;
      w = w || wready;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    do @(negedge clk); while (!bvalid);
    resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [5:0] i);
    logic a;
    @(posedge clk);
    {arvalid, rready} <= 2'h3;
    araddr <= {i, 2'h0};
    a = 1'b0;
    while (!a) begin
      @(negedge clk);
      a = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic ev(input logic [7:0] mm, input logic [7:0] gg);
    @(posedge clk);
    {moduleEvents, generalInputEvents} <= {mm, gg};
    @(posedge clk);
    {moduleEvents, generalInputEvents} <= 16'h0000;
  endtask
  task automatic st;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rst;
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
  endtask
  // ==========================================================================
  initial begin
    #400000;
    error_cnt++;
    final_report;
  end
  initial begin
    rst;
    chk("outputs", {powerWakeRequest_n, systemMgmtInterrupt_n, powerButtonPulseS3En, irq}, 4'hC);
    for (b = 2; b < 6; b++) begin
      rdr(ix[b]);
      chk("reset value", rd, 32'h0);
    end
    repeat (6) begin
      v = 8'($random(seed));
      m = 8'($random(seed));
      wr(ix[2], v);
      chk("write answer", resp, wake_event_pkg::RESP_OKAY);
      wr(ix[2], ~v, 4'h0);
      rdr(ix[2]);
      chk("enable 0", rd, {24'h0, v});
      wr(ix[3], ~v);
      rdr(ix[3]);
      chk("enable 1", rd, {24'h0, ~v});
      wr(ix[4], v);
      rdr(ix[4]);
      chk("configuration", rd, {24'h0, v & 8'h0F});
      chk("button pulse", powerButtonPulseS3En, v[3]);
      @(posedge clk);
      {keyboardClockIn, keyboardDataIn, mouseClockIn, mouseDataIn} <= m[3:0];
      st;
      chk("swap", {keysCtrlKeyboardClock, keysCtrlKeyboardData, keysCtrlMouseClock,
        keysCtrlMouseData}, expSwap(v[2], m[3:0]));
    end
    wr(6'h3F, 8'h01);
    chk("unmapped write", resp, wake_event_pkg::RESP_DECERR);
    rdr(6'h3F);
    chk("unmapped read", {resp, rd[7:0]}, {wake_event_pkg::RESP_DECERR, 8'h00});
    wr(ix[4], 8'h00);
    wr(ix[5], 8'hFF);
    wr(ix[4], {6'h00, wake_event_pkg::BANK_ROUTING});
    rdr(ix[5]);
    chk("smi other bank", rd, 32'h0);
    wr(ix[5], 8'hFF);
    rdr(ix[5]);
    chk("smi map", rd, 32'h5F);
    wr(ix[4], 8'h01);
    rdr(ix[5]);
    chk("smi hidden", rd, 32'h0);
    wr(ix[4], {6'h00, wake_event_pkg::BANK_ROUTING});
    wr(ix[2], 8'h00);
    wr(ix[3], 8'h00);
    wr(ix[0], 8'hBF);
    wr(ix[1], 8'hFF);
    for (b = 0; b < 16; b++) if (b != 6) begin
      m = 8'h01 << b[2:0];
      v = 8'($random(seed));
      wr(ix[6 + b[3]], v);
      wr(ix[5], b[3] ? 8'h00 : m);
      ev(b[3] ? 8'h00 : m, b[3] ? m : 8'h00);
      st;
      chk("smi routed", {smiSeen, wakeSeen}, {!b[3] && (m & 8'h5F) != 0, 1'b0});
      chk("irq", irq, |(v & m));
      wr(ix[2 + b[3]], m);
      st;
      chk("wake", wakeSeen, 1'b1);
      wr(ix[b[3]], 8'h00);
      st;
      chk("sticky", wakeSeen, 1'b1);
      wr(ix[b[3]], m);
      st;
      chk("cleared", {wakeSeen, smiSeen, irq}, 3'h0);
      wr(ix[2 + b[3]], 8'h00);
    end
    wr(ix[2], 8'h40);
    for (b = 0; b < 2; b++) begin
      wr(ix[0], 8'h40);
      st;
      rdr(ix[0]);
      chk("software toggle", {rd[7:0], wakeSeen}, b ? 9'h000 : 9'h081);
    end
    wr(ix[4], 8'h0C);
    rst;
    chk("second reset outputs",
      {powerWakeRequest_n, systemMgmtInterrupt_n, powerButtonPulseS3En, irq}, 4'hC);
    rdr(ix[4]);
    chk("second reset", rd, 32'h0);
    final_report;
  end
endmodule // wake_event_enable_routing_test

// [wake_event_pkg.sv]
// constants shared by the wake event enable and routing block
package wake_event_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_STATUS_0     = 6'h00;
  localparam logic [5:0] IDX_STATUS_1     = 6'h01;
  localparam logic [5:0] IDX_WAKE_EN_0    = 6'h02;
  localparam logic [5:0] IDX_WAKE_EN_1    = 6'h03;
  localparam logic [5:0] IDX_WAKE_CFG     = 6'h04;
  localparam logic [5:0] IDX_SMI_EN_0     = 6'h13;
  localparam logic [5:0] IDX_IRQ_MASK_0   = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK_1   = 6'h21;

  // ==========================================================================
  // reset values and writable-bit masks
  localparam logic [7:0] RESET_VALUE      = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK   = 8'h0F;
  localparam logic [7:0] SMI_WRITE_MASK   = 8'h5F;

  // ==========================================================================
  // field positions
  localparam int         SW_EVENT_BIT     = 6;
  localparam int         CFG_PB_S3_BIT    = 3;
  localparam int         CFG_SWAP_BIT     = 2;
  localparam logic [1:0] BANK_ROUTING     = 2'h2;

  // ==========================================================================
  // bus answers and widths
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_DECERR      = 2'h3;
  localparam int         BUS_ADDR_WIDTH   = 8;
  localparam int         BUS_DATA_WIDTH   = 32;

endpackage : wake_event_pkg
